//--- hdl/pllc_ch_if.sv
`timescale 1ns/1ps
interface pllc_ch_if;
   logic        run;
   logic        ref_edge;
   logic        fb_edge;
   logic        ext_fb;
   logic [7:0]  m;
   logic [7:0]  k;
   logic [3:0]  n;
   logic [3:0]  v;
   logic        use_v;
   logic [1:0]  quarter;
   logic [11:0] delay;
   logic        lock;
   logic        timeout;
   logic        clk_out;
   modport ctl (output run, ref_edge, fb_edge, ext_fb, m, k, n, v, use_v, quarter, delay,
                input lock, timeout, clk_out);
   modport chan (input run, ref_edge, fb_edge, ext_fb, m, k, n, v, use_v, quarter, delay,
                 output lock, timeout, clk_out);
endinterface : pllc_ch_if

//--- hdl/pllc_chan.sv
`timescale 1ns/1ps
module pllc_chan (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   pllc_ch_if.chan  ch
);
   import pllc_pkg::*;
   typedef struct packed {
      logic [15:0] per;
      logic [15:0] last;
      logic [3:0]  stable;
      logic        fb_seen;
      logic        lock;
      logic [11:0] acq;
      logic        timeout;
      logic [13:0] acc;
      logic [15:0] ocnt;
      logic [15:0] out_per;
      logic [16:0] dly;
      logic        busy;
      logic [2:0]  pend;
      logic        clk;
   } pllc_chst_s;
   pllc_chst_s q, d;
   logic [4:0]  n_e;
   logic [4:0]  v_e;
   logic [11:0] nk;
   logic [16:0] full;
   logic [16:0] sh;
   logic [15:0] diff;
   logic        emit;
   logic        fire;
   // a zero field stands for 16, which the 4-bit field cannot hold
   assign n_e  = (ch.n == 4'h0) ? 5'h10 : {1'b0, ch.n};
   assign v_e  = (ch.v == 4'h0) ? 5'h10 : {1'b0, ch.v};
   assign nk   = 12'(n_e) * (ch.use_v ? 12'(v_e) : {4'h0, ch.k});
   assign full = {q.out_per, 1'b0};
   assign diff = (q.per > q.last) ? q.per - q.last : q.last - q.per;
   assign emit = (q.acc >= {2'b00, nk}) && (nk != 12'h000);
   always_comb begin
      logic [18:0] qs;
      qs = (19'(ch.quarter) * 19'(full)) >> 2;
      sh = 17'(qs) + {5'h00, ch.delay};
      if (sh > full)
         sh = full;
   end
   assign fire = q.busy && (q.dly == 17'h00001);
   always_comb begin
      d = q;
      if (!ch.run) begin
         d = '0;
      end else begin
         d.per = (q.per == PER_MAX) ? q.per : q.per + 16'h0001;
         if (ch.fb_edge)
            d.fb_seen = 1'b1;
         if (ch.ref_edge) begin
            d.per = 16'h0001;
            d.last = q.per;
            d.fb_seen = ch.fb_edge;
            if (diff <= PER_TOL && q.last != 16'h0000 && (q.fb_seen || !ch.ext_fb)) begin
               if (q.stable != LOCK_STABLE)
                  d.stable = q.stable + 4'h1;
               else
                  d.lock = 1'b1;
            end else begin
               d.stable = 4'h0;
               d.lock = 1'b0;
            end
         end
         if (q.per == PER_MAX) begin
            d.lock = 1'b0;
            d.stable = 4'h0;
         end
         if (q.lock)
            d.acq = 12'h000;
         else if (!q.timeout)
            d.acq = q.acq + 12'h001;
         if (!q.lock && q.acq == 12'(LOCK_ACQ_CYC - 1))
            d.timeout = 1'b1;
         d.acc = q.acc + (ch.ref_edge ? {5'h00, ch.m, 1'b0} : 14'h0000)
                 - (emit ? {2'b00, nk} : 14'h0000);
         d.ocnt = emit ? 16'h0001 : q.ocnt + 16'h0001;
         if (emit)
            d.out_per = q.ocnt;
         // when shift exceeds a half period, up to 7 toggles queue and each fires sh cycles after the one before
         if (q.busy)
            d.dly = q.dly - 17'h00001;
         if (fire) begin
            d.clk = ~q.clk;
            d.busy = (q.pend != 3'h0) || emit;
            d.dly = sh;
            if (q.pend != 3'h0 && !emit)
               d.pend = q.pend - 3'h1;
         end else if (emit) begin
            if (sh == 17'h00000 && !q.busy)
               d.clk = ~q.clk;
            else if (!q.busy) begin
               d.busy = 1'b1;
               d.dly = sh;
            end else if (q.pend != 3'h7)
               d.pend = q.pend + 3'h1;
         end
      end
   end
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN)
         q <= '0;
      else
         q <= d;
   end
   assign ch.lock    = q.lock;
   assign ch.timeout = q.timeout;
   assign ch.clk_out = q.clk;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   sequence s_stable_edge;
      ch.run && ch.ref_edge && diff <= PER_TOL && q.stable == LOCK_STABLE && q.last != 16'h0000;
   endsequence
   a_lock_off_idle: assert property (!ch.run |=> !ch.lock && !ch.clk_out)
      else $error("lock or clock active while channel idle");
   a_lock_rise_cause: assert property ($rose(ch.lock) |-> $past(q.stable) == LOCK_STABLE)
      else $error("lock rose without a stable run");
   a_lock_on_stable: assert property (s_stable_edge ##0 (q.fb_seen || !ch.ext_fb) |=> ch.lock)
      else $error("stable reference did not give lock");
   a_acq_timeout: assert property ($rose(ch.timeout) |-> !ch.lock && $past(q.acq) == 12'(LOCK_ACQ_CYC - 1))
      else $error("timeout not at acquisition bound");
   a_shift_bound: assert property (ch.run && (fire || (emit && !q.busy && sh != 17'h00000)) |=> q.dly <= $past(full))
      else $error("shift exceeds one period");
endmodule : pllc_chan

//--- hdl/pllc_pkg.sv
package pllc_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_BOOST = 8'h04;
   localparam logic [7:0] A_STAT  = 8'h08;
   localparam logic [7:0] A_ERR   = 8'h0c;
   localparam logic [3:0] CH_DIV  = 4'h0;
   localparam logic [3:0] CH_SHF  = 4'h4;
   localparam logic [3:0] CH_PAGE0 = 4'h1;
   localparam int C_DONE = 0;
   localparam int C_ENH  = 1;
   localparam int C_DUAL = 2;
   localparam int C_LKEN = 4;
   localparam int B_F1   = 0;
   localparam int B_F2   = 2;
   localparam int S_TOUT = 4;
   localparam int S_URUN = 8;
   localparam int DV_M = 0;
   localparam int DV_K = 8;
   localparam int DV_N = 16;
   localparam int DV_V = 20;
   localparam int DV_USEV = 24;
   localparam int DIV_W = 25;
   localparam int SH_Q = 0;
   localparam int SH_D = 4;
   localparam int SH_EXTFB = 16;
   localparam int SHF_W = 17;
   localparam logic [DIV_W-1:0] DIV_RST = 25'h0110202;
   localparam logic [7:0] M_MIN = 8'h02;
   localparam logic [7:0] M_MAX = 8'ha0;
   localparam logic [3:0] N_MIN = 4'h1;
   localparam logic [3:0] N_MAX = 4'hf;
   localparam int LOCK_TIME_NS = 10000;
   localparam int CLK_NS = 5;
   localparam int LOCK_ACQ_CYC = LOCK_TIME_NS / CLK_NS;
   localparam logic [3:0] LOCK_STABLE = 4'h8;
   localparam logic [15:0] PER_TOL = 16'h0002;
   localparam logic [15:0] PER_MAX = 16'hffff;
   typedef enum logic [1:0] {F_X1, F_X2, F_X4} pllc_fact_e;
endpackage : pllc_pkg

//--- hdl/pllc_top.sv
`timescale 1ns/1ps
// Behaviour
// - with both paths used, first path factor must not exceed second path factor
// - shared input may feed both paths; first input is then unused
// - output rate is input times m/(n*k) or m/(n*v), m,k 2..160, n,v 1..16
// - generated clock phase set in quarter-period steps
// - delay adjustable by any amount up to one output period
// - each PLL drives its lock output high once locked
// - lock output optional per PLL; disabled pin acts as user I/O
// - PLL set up before user logic starts at end of configuration
// - base family locks during configuration and is usable right after
// - enhanced family ignores reference until configuration is complete
// - lock acquired within ten microseconds of a valid reference
// - each PLL runs independently; two or four per device
// - two PLLs can multiply a slow source-synchronous clock for serial capture
// - output may go off-chip; feedback may return through an external path
module pllc_top #(
   parameter int NUM_PLL = 4
) (
   input  wire logic                   SYS_CLK,
   input  wire logic                   RSTN,
   input  wire logic [pllc_pkg::AW-1:0] ADDR,
   input  wire logic [pllc_pkg::DW-1:0] WDATA,
   input  wire logic                   WR,
   input  wire logic                   RD,
   output      logic [pllc_pkg::DW-1:0] RDATA,
   input  wire logic [NUM_PLL-1:0]     REF_CLK_IN,
   input  wire logic [NUM_PLL-1:0]     FB_CLK_IN,
   output      logic [NUM_PLL-1:0]     GEN_CLK_OUT,
   output      logic [NUM_PLL-1:0]     LOCK_PIN_O,
   output      logic [NUM_PLL-1:0]     LOCK_PIN_OE_N,
   input  wire logic [NUM_PLL-1:0]     LOCK_PIN_I,
   input  wire logic [NUM_PLL-1:0]     USER_IO_O,
   input  wire logic [NUM_PLL-1:0]     USER_IO_OE_N,
   output      logic [NUM_PLL-1:0]     USER_IO_I,
   output      logic                   USER_RUN
);
   import pllc_pkg::*;

   typedef struct packed {
      logic [NUM_PLL-1:0]            ref_s1;
      logic [NUM_PLL-1:0]            ref_s2;
      logic [NUM_PLL-1:0]            ref_s3;
      logic [NUM_PLL-1:0]            fb_s1;
      logic [NUM_PLL-1:0]            fb_s2;
      logic [NUM_PLL-1:0]            fb_s3;
      logic [NUM_PLL-1:0]            uio_s1;
      logic [NUM_PLL-1:0]            uio_s2;
      logic                          done;
      logic                          enh;
      logic                          dual;
      logic                          user_run;
      logic [NUM_PLL-1:0]            lock_en;
      logic [1:0]                    f1;
      logic [1:0]                    f2;
      logic                          err_rng;
      logic                          err_combo;
      logic [NUM_PLL-1:0][DIV_W-1:0] div;
      logic [NUM_PLL-1:0][SHF_W-1:0] shf;
      logic [DW-1:0]                 rdata;
   } pllc_state_s;

   pllc_state_s        q;
   pllc_state_s        d;
   logic [NUM_PLL-1:0] ref_e;
   logic [NUM_PLL-1:0] fb_e;
   logic [NUM_PLL-1:0] lock;
   logic [NUM_PLL-1:0] tout;
   logic [NUM_PLL-1:0] gclk;
   logic               pll_run;
   logic [3:0]         ch_idx;
   logic               ch_hit;
   logic               div_ok;

   // two or four PLLs; the first two double as serial-capture multipliers
   if (NUM_PLL != 2 && NUM_PLL != 4)
      $error("NUM_PLL must be 2 or 4");

   assign ch_idx = ADDR[7:4] - CH_PAGE0;
   assign ch_hit = (ADDR[7:4] >= CH_PAGE0) && (ch_idx < 4'(NUM_PLL));

   function automatic logic rng_ok(input logic [DW-1:0] w);
      logic [7:0] m;
      logic [7:0] k;
      logic [3:0] n;
      logic [3:0] v;
      m = w[DV_M +: 8];
      k = w[DV_K +: 8];
      n = w[DV_N +: 4];
      v = w[DV_V +: 4];
      // 16 cannot be held in the 4-bit field, so zero stands for it
      rng_ok = m >= M_MIN && m <= M_MAX && k >= M_MIN && k <= M_MAX
               && (n >= N_MIN || n == 4'h0) && (v >= N_MIN || v == 4'h0);
   endfunction : rng_ok

   assign div_ok = rng_ok(WDATA);

   // base family runs its loop during configuration, enhanced waits for done
   assign pll_run = q.enh ? q.done : 1'b1;

   always_comb begin
      d = q;
      d.ref_s1 = REF_CLK_IN;
      d.ref_s2 = q.ref_s1;
      d.ref_s3 = q.ref_s2;
      d.fb_s1 = FB_CLK_IN;
      d.fb_s2 = q.fb_s1;
      d.fb_s3 = q.fb_s2;
      d.uio_s1 = LOCK_PIN_I;
      d.uio_s2 = q.uio_s1;
      // user logic starts one cycle after the PLLs are released
      d.user_run = q.done;
      d.rdata = '0;
      if (WR) begin
         if (ADDR == A_CTRL) begin
            if (!q.done) begin
               d.enh = WDATA[C_ENH];
               d.lock_en = WDATA[C_LKEN +: NUM_PLL];
               if (WDATA[C_DUAL] && q.f1 > q.f2)
                  d.err_combo = 1'b1;
               else
                  d.dual = WDATA[C_DUAL];
            end
            d.done = q.done | WDATA[C_DONE];
         end else if (ADDR == A_BOOST) begin
            if (!q.done) begin
               if (q.dual && WDATA[B_F1 +: 2] > WDATA[B_F2 +: 2]) begin
                  d.err_combo = 1'b1;
               end else if (WDATA[B_F1 +: 2] > 2'(F_X4) || WDATA[B_F2 +: 2] > 2'(F_X4)) begin
                  d.err_combo = 1'b1;
               end else begin
                  d.f1 = WDATA[B_F1 +: 2];
                  d.f2 = WDATA[B_F2 +: 2];
               end
            end
         end else if (ADDR == A_ERR) begin
            if (WDATA[0])
               d.err_rng = 1'b0;
            if (WDATA[1])
               d.err_combo = 1'b0;
         end else if (ch_hit && ADDR[3:0] == CH_DIV) begin
            // settings belong to the configuration image, frozen once done
            if (!q.done) begin
               if (div_ok)
                  d.div[ch_idx[1:0]] = WDATA[DIV_W-1:0];
               else
                  d.err_rng = 1'b1;
            end
         end else if (ch_hit && ADDR[3:0] == CH_SHF) begin
            if (!q.done)
               d.shf[ch_idx[1:0]] = WDATA[SHF_W-1:0];
         end
      end
      if (RD) begin
         if (ADDR == A_CTRL) begin
            d.rdata[C_DONE] = q.done;
            d.rdata[C_ENH] = q.enh;
            d.rdata[C_DUAL] = q.dual;
            d.rdata[C_LKEN +: NUM_PLL] = q.lock_en;
         end else if (ADDR == A_BOOST) begin
            d.rdata[B_F1 +: 2] = q.f1;
            d.rdata[B_F2 +: 2] = q.f2;
         end else if (ADDR == A_STAT) begin
            d.rdata[0 +: NUM_PLL] = lock;
            d.rdata[S_TOUT +: NUM_PLL] = tout;
            d.rdata[S_URUN] = q.user_run;
         end else if (ADDR == A_ERR) begin
            d.rdata[0] = q.err_rng;
            d.rdata[1] = q.err_combo;
         end else if (ch_hit && ADDR[3:0] == CH_DIV) begin
            d.rdata[DIV_W-1:0] = q.div[ch_idx[1:0]];
         end else if (ch_hit && ADDR[3:0] == CH_SHF) begin
            d.rdata[SHF_W-1:0] = q.shf[ch_idx[1:0]];
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         q <= '0;
         q.div <= {NUM_PLL{DIV_RST}};
      end else begin
         q <= d;
      end
   end

   assign fb_e = q.fb_s2 & ~q.fb_s3;

   for (genvar i = 0; i < NUM_PLL; i++) begin : g_pll
      pllc_ch_if chi ();
      logic [1:0] fsel;
      logic       raw_e;
      assign raw_e = q.ref_s2[i] & ~q.ref_s3[i];
      // in dual use path 0 hangs on the shared input and its own pin is dead
      if (i == 0) begin : g_sel
         assign ref_e[i] = q.dual ? (q.ref_s2[1] & ~q.ref_s3[1]) : raw_e;
      end else begin : g_own
         assign ref_e[i] = raw_e;
      end
      assign fsel = (i == 0) ? q.f1 : q.f2;
      assign chi.run      = pll_run;
      assign chi.ref_edge = ref_e[i];
      assign chi.ext_fb   = q.shf[i][SH_EXTFB];
      assign chi.fb_edge  = fb_e[i];
      // base family has only the fixed x1/x2/x4 boost, no divider
      assign chi.m        = q.enh ? q.div[i][DV_M +: 8] : 8'h01 << fsel;
      assign chi.k        = q.enh ? q.div[i][DV_K +: 8] : 8'h01;
      assign chi.n        = q.enh ? q.div[i][DV_N +: 4] : 4'h1;
      assign chi.v        = q.enh ? q.div[i][DV_V +: 4] : 4'h1;
      assign chi.use_v    = q.enh & q.div[i][DV_USEV];
      assign chi.quarter  = q.enh ? q.shf[i][SH_Q +: 2] : 2'b00;
      assign chi.delay    = q.enh ? q.shf[i][SH_D +: 12] : 12'h000;
      pllc_chan u_chan (
         .SYS_CLK (SYS_CLK),
         .RSTN    (RSTN),
         .ch      (chi.chan)
      );
      assign lock[i] = chi.lock;
      assign tout[i] = chi.timeout;
      assign gclk[i] = chi.clk_out;
      assign LOCK_PIN_O[i] = q.lock_en[i] ? lock[i] : USER_IO_O[i];
      assign LOCK_PIN_OE_N[i] = q.lock_en[i] ? 1'b0 : USER_IO_OE_N[i];

      a_pin_user_io: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
         !q.lock_en[i] |-> LOCK_PIN_O[i] == USER_IO_O[i] && LOCK_PIN_OE_N[i] == USER_IO_OE_N[i])
         else $error("disabled lock pin not acting as user io");
      a_pin_lock_out: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
         q.lock_en[i] |-> !LOCK_PIN_OE_N[i] && LOCK_PIN_O[i] == lock[i])
         else $error("enabled lock pin not driving lock");
   end

   assign GEN_CLK_OUT = gclk;
   assign USER_IO_I = q.uio_s2;
   assign USER_RUN = q.user_run;
   assign RDATA = q.rdata;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   sequence s_div_write;
      WR && ch_hit && ADDR[3:0] == CH_DIV && !q.done;
   endsequence
   sequence s_stat_read;
      RD && ADDR == A_STAT;
   endsequence

   a_combo_legal: assert property (q.dual |-> q.f1 <= q.f2)
      else $error("illegal factor pair with both paths used");
   a_combo_reject: assert property (WR && ADDR == A_BOOST && !q.done && q.dual
      && WDATA[B_F1 +: 2] > WDATA[B_F2 +: 2] |=> q.err_combo && $stable(q.f1))
      else $error("illegal factor pair not refused");
   a_div_range: assert property (s_div_write ##0 !div_ok |=> q.err_rng && $stable(q.div))
      else $error("out of range factor accepted");
   a_pll_first: assert property ($rose(q.done) |-> !USER_RUN ##1 USER_RUN)
      else $error("user logic not released one cycle after pll");
   a_enh_wait: assert property (q.enh && !q.done |-> lock == '0)
      else $error("enhanced pll locked before configuration done");
   a_stat_read: assert property (s_stat_read |=> RDATA[NUM_PLL-1:0] == $past(lock))
      else $error("status read does not show lock");
   a_frozen_cfg: assert property (q.done |=> $stable(q.div) && $stable(q.shf) && $stable(q.enh))
      else $error("pll settings changed after configuration");
endmodule : pllc_top

//--- test/pllc_ref_src.sv
`timescale 1ns/1ps
module pllc_ref_src (
   input  wire logic        en,
   input  wire logic [15:0] half_ns,
   output      logic        ref_o
);
   // free-running board oscillator, phase unrelated to the system clock
   // 40 ns period lies inside the input range of every factor, so the
   // bench only leaves the range when it means to break lock
   initial begin
      ref_o = 1'b0;
      #0.7;
      forever begin
         if (en) begin
            #(half_ns) ref_o = ~ref_o;
         end else begin
            ref_o = 1'b0;
            #1;
         end
      end
   end
endmodule : pllc_ref_src

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
   import pllc_pkg::*;
   localparam int NP  = 4;
   localparam int TPR = 2 * 4 / (1 * 2);
   logic          sys_clk;
   logic          rstn;
   logic [7:0]    addr;
   logic [31:0]   wdata;
   logic [31:0]   rdata;
   logic          wr;
   logic          rd;
   logic [NP-1:0] gen_clk;
   logic [NP-1:0] lock_o;
   logic [NP-1:0] lock_oe_n;
   logic [NP-1:0] lock_i;
   logic [NP-1:0] uio_o;
   logic [NP-1:0] uio_oe_n;
   logic [NP-1:0] uio_i;
   logic          user_run;
   logic          ref0;
   logic          src_en;
   logic [15:0]   half_ns;
   int            errors;
   int            compares;
   int            n;
   int            cnt;
   logic          prev;
   logic [31:0]   d;
   logic [31:0]   m_ctrl;
   logic [31:0]   m_boost;
   logic [31:0]   m_err;
   logic [31:0]   m_div[NP];
   logic [31:0]   m_shf[NP];
   logic [7:0]    rst_tab[8] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h44, 8'h80, 8'hfc};
   logic [31:0]   div_tab[7] = '{32'h00000201, 32'h00000202, 32'h000002a0, 32'h000002a1,
                                 32'h00000102, 32'h0000a102, 32'h01ffa0a0};

   always #2.5 sys_clk = ~sys_clk;

   pllc_top #(.NUM_PLL(NP)) i_pllc_top (
      .SYS_CLK(sys_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .REF_CLK_IN({2'b00, ref0, ref0}), .FB_CLK_IN({NP{ref0}}), .GEN_CLK_OUT(gen_clk),
      .LOCK_PIN_O(lock_o), .LOCK_PIN_OE_N(lock_oe_n), .LOCK_PIN_I(lock_i), .USER_IO_O(uio_o),
      .USER_IO_OE_N(uio_oe_n), .USER_IO_I(uio_i), .USER_RUN(user_run));

   pllc_ref_src i_pllc_ref_src (.en(src_en), .half_ns(half_ns), .ref_o(ref0));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic mdl_wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] nc;
      int          i;
      i = int'(a[7:4]) - 1;
      if (a == A_ERR) m_err &= ~(v & 32'h00000003);
      else if (m_ctrl[C_DONE]) ;
      else if (a == A_CTRL) begin
         nc = v & 32'h000000f7;
         if (nc[C_DUAL] && m_boost[1:0] > m_boost[3:2]) begin
            nc[C_DUAL] = m_ctrl[C_DUAL];
            m_err[1] = 1'b1;
         end
         m_ctrl = nc;
      end else if (a == A_BOOST) begin
         if (v[1:0] == 2'h3 || v[3:2] == 2'h3 || (m_ctrl[C_DUAL] && v[1:0] > v[3:2])) m_err[1] = 1'b1;
         else m_boost = v & 32'h0000000f;
      end else if (i >= 0 && i < NP && a[3:0] == CH_DIV) begin
         if (v[7:0] < M_MIN || v[7:0] > M_MAX || v[15:8] < M_MIN || v[15:8] > M_MAX) m_err[0] = 1'b1;
         else m_div[i] = v & 32'h01ffffff;
      end else if (i >= 0 && i < NP && a[3:0] == CH_SHF) m_shf[i] = v & 32'h0001ffff;
   endtask : mdl_wr

   function automatic logic [31:0] mdl_rd(input logic [7:0] a);
      int i;
      i = int'(a[7:4]) - 1;
      if (a == A_CTRL) return m_ctrl;
      if (a == A_BOOST) return m_boost;
      if (a == A_ERR) return m_err;
      if (i >= 0 && i < NP && a[3:0] == CH_DIV) return m_div[i];
      if (i >= 0 && i < NP && a[3:0] == CH_SHF) return m_shf[i];
      return 32'h00000000;
   endfunction : mdl_rd

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      mdl_wr(a, v);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a);
      logic [31:0] v;
      rd_reg(a, v);
      chk(v, mdl_rd(a));
   endtask : rd_chk

   task automatic do_reset;
      rstn <= 1'b0;
      m_ctrl  = '0;
      m_boost = '0;
      m_err   = '0;
      for (int i = 0; i < NP; i++) begin
         m_div[i] = 32'(DIV_RST);
         m_shf[i] = '0;
      end
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
   endtask : do_reset

   task automatic wait_lock(input int idx, input logic lvl, input int lim);
      n = 0;
      while (lock_o[idx] !== lvl && n < lim) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(32'(lock_o[idx]), 32'(lvl));
   endtask : wait_lock

   task automatic conclude;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   initial begin
      // whole run is about a thousand cycles; this is ample margin
      #(40000 * 5);
      errors++;
      conclude();
   end

   initial begin
      sys_clk = 1'b0; rstn = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
      uio_o = '0; uio_oe_n = '1; lock_i = '0; src_en = 1'b1; half_ns = 16'd20;
      errors = 0; compares = 0;
      void'($urandom(19));
      do_reset();
      foreach (rst_tab[j]) rd_chk(rst_tab[j]);
      @(posedge sys_clk);
      #1 chk(rdata, 32'h00000000);
      // base family runs from reset, no done needed
      n = 0;
      do begin
         rd_reg(A_STAT, d);
         n += 2;
      end while (d[0] !== 1'b1 && n < LOCK_ACQ_CYC);
      chk(32'(d[0]), 32'h1);
      do_reset();
      wr_reg(A_CTRL, 32'h00000016);
      repeat (200) @(posedge sys_clk);
      chk({30'h0, lock_o[0], lock_oe_n[0]}, 32'h0);
      for (int j = 0; j < 4; j++) begin
         uio_o <= 4'($urandom);
         uio_oe_n <= 4'($urandom);
         lock_i <= 4'($urandom);
         repeat (4) @(posedge sys_clk);
         #1;
         chk({lock_o[3:1], lock_oe_n[3:1]}, {uio_o[3:1], uio_oe_n[3:1]});
         chk(32'(uio_i), 32'(lock_i));
      end
      for (int f1 = 0; f1 < 4; f1++) begin
         for (int f2 = 0; f2 < 4; f2++) begin
            wr_reg(A_BOOST, 32'(f2 * 4 + f1));
            rd_chk(A_BOOST);
            rd_chk(A_ERR);
            wr_reg(A_ERR, 32'h00000003);
         end
      end
      // dual may not be turned on over a combination it forbids
      wr_reg(A_CTRL, 32'h00000012);
      wr_reg(A_BOOST, 32'h00000001);
      wr_reg(A_CTRL, 32'h00000016);
      rd_chk(A_CTRL);
      rd_chk(A_ERR);
      wr_reg(A_BOOST, 32'h00000000);
      wr_reg(A_CTRL, 32'h00000016);
      for (int j = 0; j < 19; j++) begin
         d = (j < 7) ? div_tab[j] : $urandom & 32'h01ffffff;
         wr_reg({4'(CH_PAGE0 + j % NP), CH_DIV}, d);
         rd_chk({4'(CH_PAGE0 + j % NP), CH_DIV});
         rd_chk(A_ERR);
         wr_reg(A_ERR, 32'h00000001);
      end
      wr_reg({4'(CH_PAGE0 + 1), CH_SHF}, $urandom);
      rd_chk({4'(CH_PAGE0 + 1), CH_SHF});
      wr_reg({CH_PAGE0, CH_DIV}, 32'h00010204);
      wr_reg({CH_PAGE0, CH_SHF}, 32'h00000000);
      wr_reg(A_CTRL, 32'h00000017);
      #1 chk(32'(user_run), 32'h0);
      @(posedge sys_clk);
      #1 chk(32'(user_run), 32'h1);
      wr_reg(A_BOOST, 32'h00000005);
      rd_chk(A_BOOST);
      wr_reg(A_CTRL, 32'h00000000);
      rd_chk(A_CTRL);
      wait_lock(0, 1'b1, LOCK_ACQ_CYC);
      rd_reg(A_STAT, d);
      chk(d & 32'h00000115, 32'h00000101);
      cnt = 0;
      prev = gen_clk[0];
      repeat (64) begin
         @(posedge sys_clk);
         #1;
         if (gen_clk[0] !== prev) cnt++;
         prev = gen_clk[0];
      end
      // eight reference periods of 8 cycles each; edge phase may shift the count by one
      chk(32'((cnt + TPR / 2) / TPR), 32'd8);
      half_ns = 16'd60;
      wait_lock(0, 1'b0, 100);
      half_ns = 16'd20;
      wait_lock(0, 1'b1, LOCK_ACQ_CYC);
      conclude();
   end
endmodule : tb
